// ==== src/tpc_top.sv ====
// Purpose: 16-bit timer with guarded configuration writes
// Assumes: register port strobes are one cycle, never both at once
// Notes:   counter arithmetic kept minimal; guards are the focus
// How it works
// - Capture edge fields change only when stopped
// - Level bit drives pin even when disabled
// - Capture only in free-run and pulse-width modes
// - Event edges act with external clock or in mode 010
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
`include "tpc_regs.svh"
module tpc_top
  import tpc_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  // Clock status from the system
  input  wire logic        sub_clk_main_stopped,
  // Timer pins
  input  wire logic        cap_pin,
  input  wire logic        event_pin,
  input  wire logic        trig_pin,
  output logic      [1:0]  timer_output_pin
);
  tpc_cfg_t    cfg;
  tpc_cfg_t    next_cfg;
  logic [15:0] compare_capture_reg_0;
  logic [15:0] next_ccr0;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic [2:0]  div;
  logic [2:0]  next_div;
  logic        guard_err;
  logic        next_guard_err;
  logic        acc_block;
  logic        next_acc_block;
  logic        ovf;
  logic        next_ovf;
  logic [15:0] next_rdata;
  logic        cap_hit;
  logic        evt_hit;
  logic        trg_hit;
  logic        cap_ok;
  logic        evt_ok;
  logic        tick_int;
  logic        tick;
  logic        match;
  logic        wr_ccr0;
  logic        bad_ioc1;
  logic        bad_ioc2;
  logic        bad_opt0;
  logic        rd_stat;
  logic        stop_wr;
  logic        ccr0_blocked;

  // Strobe aimed at one register offset
  function automatic logic reg_hit(input logic       stb,
                                   input logic [3:0] a,
                                   input logic [3:0] want);
    return stb && (a == want);
  endfunction

  // Capture edges are meaningful only in these two modes
  assign cap_ok = cfg.ce && (cfg.mode == TPC_MD_FREERUN ||
                             cfg.mode == TPC_MD_PULSEW);
  // Event edge only with external clock or event/one-shot modes
  assign evt_ok = cfg.ce && (cfg.eee ||
                             cfg.mode == TPC_MD_EVENT ||
                             cfg.mode == TPC_MD_ONESHOT);

  // Edge detectors
  tpc_edge u_cap (
    .mclk (mclk),
    .rst_n(rst_n),
    .pin  (cap_pin),
    .sel  (cfg.is_sel[1:0]),
    .en   (cap_ok),
    .hit  (cap_hit)
  );

  tpc_edge u_evt (
    .mclk (mclk),
    .rst_n(rst_n),
    .pin  (event_pin),
    .sel  (cfg.ees),
    .en   (evt_ok),
    .hit  (evt_hit)
  );

  tpc_edge u_trg (
    .mclk (mclk),
    .rst_n(rst_n),
    .pin  (trig_pin),
    .sel  (cfg.ets),
    .en   (cfg.ce),
    .hit  (trg_hit)
  );

  // Output stages, one per channel
  tpc_out u_out0 (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ce    (cfg.ce),
    .oe    (cfg.oe[0]),
    .ol    (cfg.ol[0]),
    .toggle(match),
    .pin   (timer_output_pin[0])
  );

  tpc_out u_out1 (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ce    (cfg.ce),
    .oe    (cfg.oe[1]),
    .ol    (cfg.ol[1]),
    .toggle(match),
    .pin   (timer_output_pin[1])
  );

  // Prescaler enable: wraps at 1, 2, 4 or 8 cycles
  assign tick_int = ((div & ((3'h1 << cfg.presc) - 3'h1)) == 3'h0);
  assign tick     = cfg.ce && ((cfg.eee || cfg.mode == TPC_MD_EVENT)
                               ? evt_hit : tick_int);
  assign match    = tick && (cnt == compare_capture_reg_0) &&
                    !cfg.ccs[0];

  // Compare 0 is not reachable while main clock is stopped
  assign wr_ccr0  = reg_hit(wr, addr, `TPC_A_CCR0) &&
                    !sub_clk_main_stopped;

  // Any compare 0 access on a stopped main clock is dropped and noted
  assign ccr0_blocked = reg_hit(wr || rd, addr, `TPC_A_CCR0) &&
                        sub_clk_main_stopped;
  // Status read clears the overflow and blocked-access flags; a same-cycle set still wins
  assign rd_stat      = reg_hit(rd, addr, `TPC_A_STAT);
  // Writing CE low is the recovery step after a bad running change
  assign stop_wr      = reg_hit(wr, addr, `TPC_A_CTL0) &&
                        !wdata[`TPC_CE_BIT];

  // A running write that would alter a guarded field
  assign bad_ioc1 = wr && addr == `TPC_A_IOC1 &&
                    tpc_guard_bad(cfg.ce, cfg.is_sel,
                                  wdata[3:0]);
  assign bad_ioc2 = wr && addr == `TPC_A_IOC2 &&
                    tpc_guard_bad(cfg.ce, {cfg.ees, cfg.ets},
                                  wdata[3:0]);
  assign bad_opt0 = wr && addr == `TPC_A_OPT0 &&
                    tpc_guard_bad(cfg.ce, {2'h0, cfg.ccs},
                                  {2'h0, wdata[`TPC_CCS1_BIT],
                                   wdata[`TPC_CCS0_BIT]});

  // Configuration writes; refused guarded changes keep old value
  always_comb begin
    next_cfg = cfg;
    if (wr) begin
      unique case (addr)
        `TPC_A_CTL0: begin
          next_cfg.ce    = wdata[`TPC_CE_BIT];
          next_cfg.presc = wdata[`TPC_PRS_LSB +: 2];
        end
        `TPC_A_CTL1: begin
          next_cfg.eee  = wdata[`TPC_EEE_BIT];
          next_cfg.mode = tpc_mode_t'(wdata[`TPC_MD_LSB +: 3]);
        end
        `TPC_A_IOC0: begin
          next_cfg.oe = {wdata[2], wdata[0]};
          next_cfg.ol = {wdata[3], wdata[1]};
        end
        `TPC_A_IOC1: begin
          if (!bad_ioc1) begin
            next_cfg.is_sel = wdata[3:0];
          end
        end
        `TPC_A_IOC2: begin
          if (!bad_ioc2) begin
            next_cfg.ees = wdata[`TPC_EES_LSB +: 2];
            next_cfg.ets = wdata[`TPC_ETS_LSB +: 2];
          end
        end
        `TPC_A_OPT0: begin
          if (!bad_opt0) begin
            next_cfg.ccs = {wdata[`TPC_CCS1_BIT],
                            wdata[`TPC_CCS0_BIT]};
          end
        end
        default: begin
          next_cfg = cfg;
        end
      endcase
    end
  end

  // Error flag: set wins over the clear made by stopping
  always_comb begin
    next_guard_err = guard_err;
    if (stop_wr) begin
      next_guard_err = 1'b0;
    end
    if (bad_ioc1 || bad_ioc2 || bad_opt0) begin
      next_guard_err = 1'b1;
    end
  end

  // Blocked-access flag, cleared by reading the status register
  always_comb begin
    next_acc_block = acc_block;
    if (rd_stat) begin
      next_acc_block = 1'b0;
    end
    if (ccr0_blocked) begin
      next_acc_block = 1'b1;
    end
  end

  // Counter, compare and capture
  always_comb begin
    next_div  = cfg.ce ? div + 3'h1 : 3'h0;
    next_cnt  = cnt;
    next_ccr0 = compare_capture_reg_0;
    next_ovf  = ovf;
    if (rd_stat) begin
      next_ovf = 1'b0;
    end
    if (!cfg.ce) begin
      next_cnt = `TPC_RST_WORD;
    end else if (trg_hit && (cfg.mode == TPC_MD_EXT_TRIG ||
                             cfg.mode == TPC_MD_ONESHOT)) begin
      next_cnt = `TPC_RST_WORD;
    end else if (tick) begin
      if (match && cfg.mode != TPC_MD_FREERUN) begin
        next_cnt = `TPC_RST_WORD;
      end else begin
        next_cnt = cnt + 16'h0001;
      end
      if (cnt == 16'hFFFF) begin
        next_ovf = 1'b1;
      end
    end
    if (cap_hit && cfg.ccs[0]) begin
      next_ccr0 = cnt;
    end else if (wr_ccr0) begin
      next_ccr0 = wdata;
    end
  end

  // Read data, valid the cycle after the strobe
  always_comb begin
    next_rdata = 16'h0000;
    if (rd) begin
      unique case (addr)
        `TPC_A_CTL0: next_rdata = {8'h00, cfg.ce, 5'h00, cfg.presc};
        `TPC_A_CTL1: next_rdata = {10'h000, cfg.eee, 2'h0, cfg.mode};
        `TPC_A_IOC0: next_rdata = {12'h000, cfg.ol[1], cfg.oe[1],
                                   cfg.ol[0], cfg.oe[0]};
        `TPC_A_IOC1: next_rdata = {12'h000, cfg.is_sel};
        `TPC_A_IOC2: next_rdata = {12'h000, cfg.ees, cfg.ets};
        `TPC_A_OPT0: next_rdata = {10'h000, cfg.ccs, 4'h0};
        `TPC_A_CCR0: begin
          next_rdata = sub_clk_main_stopped ? 16'h0000
                                            : compare_capture_reg_0;
        end
        `TPC_A_STAT: next_rdata = {13'h0000, ovf, acc_block,
                                   guard_err};
        `TPC_A_CNT:  next_rdata = cnt;
        default:     next_rdata = 16'h0000;
      endcase
    end
  end

  // State registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg                   <= '0;
      compare_capture_reg_0 <= `TPC_RST_WORD;
      cnt                   <= `TPC_RST_WORD;
      div                   <= 3'h0;
      guard_err             <= 1'b0;
      acc_block             <= 1'b0;
      ovf                   <= 1'b0;
      rdata                 <= 16'h0000;
    end else begin
      cfg                   <= next_cfg;
      compare_capture_reg_0 <= next_ccr0;
      cnt                   <= next_cnt;
      div                   <= next_div;
      guard_err             <= next_guard_err;
      acc_block             <= next_acc_block;
      ovf                   <= next_ovf;
      rdata                 <= next_rdata;
    end
  end
endmodule

// ==== src/tpc_regs.svh ====
// Purpose: register offsets, field positions, reset values and counts
// Assumes: plain 4-bit address port, 16-bit data port
// Notes:   definitions only
`ifndef TPC_REGS_SVH
`define TPC_REGS_SVH

// Register offsets
`define TPC_A_CTL0    4'h0
`define TPC_A_CTL1    4'h1
`define TPC_A_IOC0    4'h2
`define TPC_A_IOC1    4'h3
`define TPC_A_IOC2    4'h4
`define TPC_A_OPT0    4'h5
`define TPC_A_CCR0    4'h6
`define TPC_A_STAT    4'h7
`define TPC_A_CNT     4'h8

// Field positions
`define TPC_CE_BIT    7
`define TPC_PRS_LSB   0
`define TPC_EEE_BIT   5
`define TPC_MD_LSB    0
`define TPC_CCS0_BIT  4
`define TPC_CCS1_BIT  5
`define TPC_ETS_LSB   0
`define TPC_EES_LSB   2

// Reset values
`define TPC_RST_BYTE  8'h00
`define TPC_RST_WORD  16'h0000

// Prescaler divides by 1, 2, 4 or 8
`define TPC_DIV_W     3

`endif

// ==== src/tpc_pkg.sv ====
// Purpose: types shared by the timer guard block
// Assumes: nothing
// Notes:   mode codes follow the documented field values
package tpc_pkg;

  typedef enum logic [2:0] {
    TPC_MD_INTERVAL = 3'h0,
    TPC_MD_EXT_TRIG = 3'h1,
    TPC_MD_EVENT    = 3'h2,
    TPC_MD_ONESHOT  = 3'h3,
    TPC_MD_PWM      = 3'h4,
    TPC_MD_FREERUN  = 3'h5,
    TPC_MD_PULSEW   = 3'h6,
    TPC_MD_RSVD     = 3'h7
  } tpc_mode_t;

  // Whole configuration as seen by the counting logic
  typedef struct packed {
    logic       ce;
    logic [1:0] presc;
    logic       eee;
    tpc_mode_t  mode;
    logic [1:0] oe;
    logic [1:0] ol;
    logic [3:0] is_sel;
    logic [1:0] ees;
    logic [1:0] ets;
    logic [1:0] ccs;
  } tpc_cfg_t;

  // True when a write would change a field while counting
  function automatic logic tpc_guard_bad(input logic ce,
                                         input logic [3:0] old_v,
                                         input logic [3:0] new_v);
    return ce && (old_v != new_v);
  endfunction

endpackage

// ==== src/tpc_edge.sv ====
// Purpose: selectable edge detector on a timer input pin
// Assumes: pin is synchronous to mclk
// Notes:   sel 00 none, 01 rising, 10 falling, 11 both
`timescale 1ns/1ps
module tpc_edge
  import tpc_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Pin and selection
  input  wire logic       pin,
  input  wire logic [1:0] sel,
  input  wire logic       en,
  // Detected edge, one cycle
  output logic            hit
);
  logic prev;
  logic next_prev;
  logic next_hit;

  // Edge match against selection
  always_comb begin
    next_prev = pin;
    next_hit  = en && ((sel[0] && pin && !prev) ||
                       (sel[1] && !pin && prev));
  end

  // Register sample and pulse
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= 1'b0;
      hit  <= 1'b0;
    end else begin
      prev <= next_prev;
      hit  <= next_hit;
    end
  end
endmodule

// ==== src/tpc_out.sv ====
// Purpose: one timer output channel
// Assumes: toggle is a one-cycle pulse from the compare logic
// Notes:   level bit drives the pin directly while stopped
`timescale 1ns/1ps
module tpc_out
  import tpc_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Control
  input  wire logic ce,
  input  wire logic oe,
  input  wire logic ol,
  input  wire logic toggle,
  // Pin
  output logic      pin
);
  logic phase;
  logic next_phase;
  logic next_pin;

  // Phase runs only while counting; pin follows level when idle
  always_comb begin
    next_phase = phase;
    if (!ce) begin
      next_phase = 1'b0;
    end else if (toggle && oe) begin
      next_phase = !phase;
    end
    next_pin = (ce && oe) ? (ol ^ next_phase) : ol;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 1'b0;
      pin   <= 1'b0;
    end else begin
      phase <= next_phase;
      pin   <= next_pin;
    end
  end
endmodule

// ==== tb/tpc_top_properties.sv ====
// Purpose: port-level checks for the timer guard block
// Assumes: CE and capture edge field shadowed from register writes
// Notes:   shadows mirror only what the port shows
`timescale 1ns/1ps
module tpc_chk (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // Register port
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  // Status and pins
  input wire logic        sub_clk_main_stopped,
  input wire logic        cap_pin,
  input wire logic        event_pin,
  input wire logic        trig_pin,
  input wire logic [1:0]  timer_output_pin
);
  logic       ce_s, err_s, next_ce, next_err, bad;
  logic [3:0] cap_s, next_cap;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Shadow next values; a refused write keeps the old field
  always_comb begin
    bad      = wr && addr == 4'h3 && ce_s && wdata[3:0] != cap_s;
    next_ce  = (wr && addr == 4'h0) ? wdata[7] : ce_s;
    next_cap = (wr && addr == 4'h3 && !bad) ? wdata[3:0] : cap_s;
    next_err = bad || (err_s && !(wr && addr == 4'h0 && !wdata[7]));
  end

  // Shadow registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ce_s  <= 1'b0;
      err_s <= 1'b0;
      cap_s <= 4'h0;
    end else begin
      ce_s  <= next_ce;
      err_s <= next_err;
      cap_s <= next_cap;
    end
  end

  sequence s_lvl;
    wr && addr == 4'h2 && !ce_s ##1 !wr [*3];
  endsequence

  property p_idle;
    !rd |=> rdata == 16'h0000;
  endproperty
  a_idle: assert property (p_idle) else $error("rdata not idle");

  property p_blocked;
    rd && addr == 4'h6 && sub_clk_main_stopped |=> rdata == 16'h0000;
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("blocked read not zero");

  property p_level;
    s_lvl |-> timer_output_pin == {$past(wdata[3], 3), $past(wdata[1], 3)};
  endproperty
  a_level: assert property (p_level)
    else $error("pin not at level bits");

  property p_cap_keep;
    rd && addr == 4'h3 |=> rdata[3:0] == $past(cap_s);
  endproperty
  a_cap_keep: assert property (p_cap_keep)
    else $error("capture edge field wrong");

  property p_err;
    rd && addr == 4'h7 && err_s |=> rdata[0];
  endproperty
  a_err: assert property (p_err)
    else $error("guard flag not set");
endmodule

bind tpc_top tpc_chk i_chk (.mclk(mclk), .rst_n(rst_n), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .sub_clk_main_stopped(sub_clk_main_stopped), .cap_pin(cap_pin),
  .event_pin(event_pin), .trig_pin(trig_pin),
  .timer_output_pin(timer_output_pin));

// ==== tb/tb.sv ====
// Purpose: self-checking bench for the timer guard block
// Assumes: read data stands one cycle after the read strobe
// Notes:   fixed waits only where the pin stage, the pin pulses or the count-up before a capture fix them
`timescale 1ns/1ps
module tb;
  logic        mclk, rst_n, wr, rd, sub_clk_main_stopped;
  logic        cap_pin, event_pin, trig_pin;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata, d, a0;
  logic [1:0]  timer_output_pin;
  int          n_mismatch, samples_checked;

  tpc_top i_dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata),
    .sub_clk_main_stopped(sub_clk_main_stopped), .cap_pin(cap_pin),
    .event_pin(event_pin), .trig_pin(trig_pin),
    .timer_output_pin(timer_output_pin));

  // 50 ns clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic complete_run();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    @(posedge mclk);
    v = rdata;
  endtask

  // Pins are synchronous, so a few cycles high is a clean edge
  task automatic pulse(input logic c);
    @(posedge mclk);
    if (c)
      cap_pin <= 1'b1;
    else
      event_pin <= 1'b1;
    repeat (3) @(posedge mclk);
    cap_pin   <= 1'b0;
    event_pin <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  // Unmapped write must disturb nothing
  task automatic t_reset();
    wr_reg(4'hF, 16'hFFFF);
    for (int i = 0; i < 9; i++) begin
      rd_reg(4'(i), d);
      chk("reset_value", d, 16'h0000);
    end
  endtask

  task automatic t_blocked();
    wr_reg(4'h6, 16'h1234);
    sub_clk_main_stopped <= 1'b1;
    wr_reg(4'h6, 16'h5678);
    rd_reg(4'h6, d);
    chk("ccr0_blocked", d, 16'h0000);
    rd_reg(4'h7, d);
    chk("stat_blocked", d & 16'h0002, 16'h0002);
    sub_clk_main_stopped <= 1'b0;
    rd_reg(4'h6, d);
    chk("ccr0_kept", d, 16'h1234);
  endtask

  // Level bits reach the pin while stopped, enable on or off
  task automatic t_level();
    logic [2:0] v;
    for (int i = 0; i < 8; i++) begin
      v = 3'(i);
      wr_reg(4'h2, {12'h000, v[1], v[2], v[0], v[2]});
      repeat (3) @(posedge mclk);
      chk("pin_level", 16'(timer_output_pin), 16'(v[1:0]));
    end
  endtask

  task automatic t_guard();
    logic [3:0]  ga [3] = '{4'h3, 4'h4, 4'h5};
    logic [15:0] va [3] = '{16'h0005, 16'h0006, 16'h0010};
    logic [15:0] vb [3] = '{16'h000A, 16'h0009, 16'h0020};
    logic [15:0] m  [3] = '{16'h000F, 16'h000F, 16'h0030};
    for (int i = 0; i < 3; i++) begin
      wr_reg(4'h0, 16'h0000);
      wr_reg(ga[i], va[i]);
      wr_reg(4'h0, 16'h0080);
      wr_reg(ga[i], va[i]);
      rd_reg(4'h7, d);
      chk("same_ok", d & 16'h0001, 16'h0000);
      wr_reg(ga[i], vb[i]);
      rd_reg(ga[i], d);
      chk("refused", d & m[i], va[i]);
      rd_reg(4'h7, d);
      chk("guard_flag", d & 16'h0001, 16'h0001);
      wr_reg(4'h0, 16'h0000);
      wr_reg(ga[i], vb[i]);
      rd_reg(ga[i], d);
      chk("reprogram", d & m[i], vb[i]);
      rd_reg(4'h7, d);
      chk("flag_clear", d & 16'h0001, 16'h0000);
    end
  endtask

  // Capture in pulse width and free-run modes, none in interval mode
  task automatic t_capture();
    logic [15:0] md [3] = '{16'h0000, 16'h0006, 16'h0005};
    wr_reg(4'h0, 16'h0000);
    wr_reg(4'h5, 16'h0010);
    wr_reg(4'h3, 16'h0001);
    for (int i = 0; i < 3; i++) begin
      wr_reg(4'h0, 16'h0000);
      wr_reg(4'h6, 16'h0000);
      wr_reg(4'h1, md[i]);
      wr_reg(4'h0, 16'h0080);
      repeat (8) @(posedge mclk);
      pulse(1'b1);
      rd_reg(4'h6, d);
      chk("capture", {15'h0000, d != 16'h0000}, {15'h0000, i > 0});
    end
  endtask

  // Event count mode with edges, with none, then external clock
  task automatic t_event();
    wr_reg(4'h0, 16'h0000);
    wr_reg(4'h5, 16'h0000);
    wr_reg(4'h3, 16'h0000);
    wr_reg(4'h6, 16'hFFFF);
    for (int i = 0; i < 3; i++) begin
      wr_reg(4'h0, 16'h0000);
      wr_reg(4'h1, (i > 1) ? 16'h0020 : 16'h0002);
      wr_reg(4'h4, (i == 1) ? 16'h0000 : 16'h0004);
      wr_reg(4'h0, 16'h0080);
      rd_reg(4'h8, a0);
      pulse(1'b0);
      pulse(1'b0);
      rd_reg(4'h8, d);
      chk("event_count", d - a0, (i == 1) ? 16'h0000 : 16'h0002);
    end
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    complete_run();
  end

  initial begin
    rst_n = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    sub_clk_main_stopped = 1'b0;
    cap_pin = 1'b0;
    event_pin = 1'b0;
    trig_pin = 1'b0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_blocked();
    t_level();
    t_guard();
    t_capture();
    t_event();
    complete_run();
  end
endmodule
